//--- verilog/cma_core_addr.sv
/*
 * Core register file and memory addressing of the 8-bit CPU core: program
 * counter with return stack, two indirect pointers, banked data memory
 * decode with shared core registers and common RAM, program memory reads
 * through the pointers, and the arithmetic status register.
 * Assumes the CPU sequencer on the same clock issues one access at a time,
 * and that program memory answers a read one clock after pfm_rd.
 */
`timescale 1ns/1ps
module cma_core_addr
  import cma_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire cma_req_type acc_req,
  output logic acc_busy,
  output logic acc_done,
  output logic [7:0] acc_rdata,
  output logic acc_hi_endurance,
  output logic pfm_rd,
  output logic [CMA_PC_W-1:0] pfm_addr,
  input wire logic [CMA_PFM_W-1:0] pfm_word,
  input wire cma_alu_type alu_in,
  input wire logic wdt_expire,
  input wire logic wdt_clear,
  input wire logic sleep_enter,
  input wire cma_pc_op_type pc_op,
  input wire logic [CMA_PC_W-1:0] pc_target,
  output logic [CMA_PC_W-1:0] pc,
  input wire logic stack_fault_reset_en,
  input wire logic stk_ovf_clear,
  input wire logic stk_unf_clear,
  output logic stack_overflow_flag,
  output logic stack_underflow_flag,
  output logic soft_reset,
  output logic [7:0] status_out,
  output logic [7:0] working_accumulator,
  output logic [7:0] bank_selector,
  output logic [7:0] interrupt_control,
  output logic [7:0] program_counter_high_latch
);

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic cma_region_type region_of(input logic [6:0] off);
    if (off < CMA_OFF_SFR) begin
      region_of = CMA_RG_CORE;
    end else if (off < CMA_OFF_GPR) begin
      region_of = CMA_RG_SFR;
    end else if (off < CMA_OFF_COMMON) begin
      region_of = CMA_RG_GPR;
    end else begin
      region_of = CMA_RG_COMMON;
    end
  endfunction

  function automatic logic [CMA_PC_W-1:0] wrap_pc(input logic [CMA_PC_W-1:0] a);
    if (LARGE_VARIANT) begin
      wrap_pc = {1'b0, a[13:0]};
    end else begin
      wrap_pc = {2'b00, a[12:0]};
    end
  endfunction

  function automatic logic in_hi_endurance(input logic [CMA_PC_W-1:0] a);
    if (LARGE_VARIANT) begin
      in_hi_endurance = &a[13:CMA_HE_LSB];
    end else begin
      in_hi_endurance = &a[12:CMA_HE_LSB];
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  cma_state_type state_q;
  logic [CMA_PC_W-1:0] pc_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [4:0] bsr_q;
  logic [7:0] working_accumulator_q;
  logic [7:0] program_counter_high_latch_q;
  logic [7:0] interrupt_control_q;
  logic [4:0] status_q;
  logic ovf_q;
  logic unf_q;
  logic soft_reset_q;
  logic [7:0] rdata_q;
  logic [7:0] core_rd_q;
  logic ram_sel_q;
  logic prog_q;
  logic he_q;
  logic pfm_rd_q;
  logic [CMA_PC_W-1:0] pfm_addr_q;

  // ****************************************
  // Effective address
  // ****************************************
  logic is_ind;
  logic [15:0] ptr;
  logic [11:0] eff_addr;
  logic eff_prog;
  logic eff_none;
  cma_region_type eff_rg;
  logic [6:0] eff_off;
  logic [4:0] eff_bank;
  logic ram_hit;
  logic core_hit;
  logic take;
  logic wr;
  logic [CMA_RAM_AW-1:0] ram_idx;
  logic [7:0] mem_rdata;
  logic [7:0] core_val;

  assign is_ind = (acc_req.offset == CMA_OFF_IND0) || (acc_req.offset == CMA_OFF_IND1);
  assign ptr = (acc_req.offset == CMA_OFF_IND1) ? ptr1_q : ptr0_q;
  // Direct accesses take the bank from the selector
  assign eff_addr = is_ind ? ptr[11:0] : {bsr_q, acc_req.offset};
  assign eff_off = eff_addr[6:0];
  assign eff_bank = eff_addr[11:7];
  assign eff_prog = is_ind && ptr[CMA_PTR_PROG_BIT];
  // Pointer beyond the banked map, or pointing at a pointer port, finds nothing
  assign eff_none = is_ind && !eff_prog && ((ptr[14:12] != 3'h0) || (eff_off[6:1] == 6'h00));
  assign eff_rg = region_of(eff_off);
  assign ram_hit = !eff_prog && !eff_none
                   && (eff_rg == CMA_RG_COMMON
                       || (eff_rg == CMA_RG_GPR && eff_bank < CMA_GPR_BANKS));
  assign core_hit = !eff_prog && !eff_none && eff_rg == CMA_RG_CORE;
  assign take = acc_valid && state_q == CMA_IDLE;
  assign wr = take && acc_req.write;

  // One physical block serves the common area of every bank
  always_comb begin
    if (eff_rg == CMA_RG_COMMON) begin
      ram_idx = {CMA_COMMON_PAGE, eff_off[3:0]};
    end else begin
      ram_idx = 8'({3'h0, eff_bank} * CMA_GPR_BYTES) + ({1'b0, eff_off} - {1'b0, CMA_OFF_GPR});
    end
  end

  // Core register read mux; bank-independent
  always_comb begin
    core_val = 8'h00;
    if (core_hit) begin
      case (eff_off)
        CMA_OFF_PCL: core_val = pc_q[7:0];
        CMA_OFF_STATUS: core_val = {3'h0, status_q};
        CMA_OFF_P0L: core_val = ptr0_q[7:0];
        CMA_OFF_P0H: core_val = ptr0_q[15:8];
        CMA_OFF_P1L: core_val = ptr1_q[7:0];
        CMA_OFF_P1H: core_val = ptr1_q[15:8];
        CMA_OFF_BSR: core_val = {3'h0, bsr_q};
        CMA_OFF_WORKING_ACCUMULATOR: core_val = working_accumulator_q;
        CMA_OFF_PROGRAM_COUNTER_HIGH_LATCH: core_val = program_counter_high_latch_q;
        CMA_OFF_INTERRUPT_CONTROL: core_val = interrupt_control_q;
        default: core_val = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Data RAM and return stack
  // ****************************************
  logic stk_push;
  logic stk_pop;
  logic [CMA_PC_W-1:0] stk_top;
  logic [CMA_PC_W-1:0] stk_data;
  logic stk_ovf;
  logic stk_unf;

  cma_mem #(
    .AW(CMA_RAM_AW),
    .DW(8)
  ) u_ram (
    .sys_clk(sys_clk),
    .we(wr && ram_hit),
    .addr(ram_idx),
    .wdata(acc_req.wdata),
    .rdata_q(mem_rdata)
  );

  assign stk_push = pc_op == CMA_PC_CALL || pc_op == CMA_PC_IRQ;
  assign stk_pop = pc_op == CMA_PC_RET;
  // A call returns past itself; an interrupt resumes the preempted word
  assign stk_data = (pc_op == CMA_PC_CALL) ? wrap_pc(pc_q + 15'h0001) : pc_q;

  cma_stack u_stack (
    .sys_clk(sys_clk),
    .rst(rst),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(stk_data),
    .top_q(stk_top),
    .overflow(stk_ovf),
    .underflow(stk_unf)
  );

  // ****************************************
  // Access sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= CMA_IDLE;
    end else begin
      case (state_q)
        CMA_IDLE: state_q <= take ? CMA_WAIT : CMA_IDLE;
        CMA_WAIT: state_q <= prog_q ? CMA_PFM : CMA_DONE;
        CMA_PFM: state_q <= CMA_DONE;
        CMA_DONE: state_q <= CMA_IDLE;
        default: state_q <= CMA_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_rd_q <= 8'h00;
      ram_sel_q <= 1'b0;
      prog_q <= 1'b0;
      pfm_rd_q <= 1'b0;
      pfm_addr_q <= '0;
    end else begin
      pfm_rd_q <= 1'b0;
      if (take) begin
        core_rd_q <= core_val;
        ram_sel_q <= ram_hit;
        prog_q <= eff_prog;
        if (eff_prog && !acc_req.write) begin
          pfm_rd_q <= 1'b1;
          pfm_addr_q <= wrap_pc(ptr[14:0]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      he_q <= 1'b0;
    end else if (state_q == CMA_WAIT && !prog_q) begin
      rdata_q <= ram_sel_q ? mem_rdata : core_rd_q;
      he_q <= 1'b0;
    end else if (state_q == CMA_PFM) begin
      rdata_q <= prog_q && !pfm_rd_q ? pfm_word[7:0] : 8'h00;
      he_q <= in_hi_endurance(pfm_addr_q);
    end
  end

  // ****************************************
  // Core register writes
  // ****************************************
  // Program-memory targets fall outside core_hit and ram_hit, so the write drops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end else if (wr && core_hit) begin
      case (eff_off)
        CMA_OFF_P0L: ptr0_q[7:0] <= acc_req.wdata;
        CMA_OFF_P0H: ptr0_q[15:8] <= acc_req.wdata;
        CMA_OFF_P1L: ptr1_q[7:0] <= acc_req.wdata;
        CMA_OFF_P1H: ptr1_q[15:8] <= acc_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bsr_q <= 5'h00;
      working_accumulator_q <= CMA_REG_RST;
      program_counter_high_latch_q <= CMA_REG_RST;
      interrupt_control_q <= CMA_REG_RST;
    end else if (wr && core_hit) begin
      case (eff_off)
        CMA_OFF_BSR: bsr_q <= acc_req.wdata[4:0];
        CMA_OFF_WORKING_ACCUMULATOR: working_accumulator_q <= acc_req.wdata;
        CMA_OFF_PROGRAM_COUNTER_HIGH_LATCH: program_counter_high_latch_q <= acc_req.wdata;
        CMA_OFF_INTERRUPT_CONTROL: interrupt_control_q <= acc_req.wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Status register
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= CMA_STATUS_RST;
    end else begin
      // Only hardware events move these two bits
      if (wdt_expire) begin
        status_q[CMA_ST_TO] <= 1'b0;
      end else if (wdt_clear || sleep_enter) begin
        status_q[CMA_ST_TO] <= 1'b1;
      end
      if (sleep_enter) begin
        status_q[CMA_ST_PD] <= 1'b0;
      end else if (wdt_clear) begin
        status_q[CMA_ST_PD] <= 1'b1;
      end
      if (alu_in.we) begin
        status_q[CMA_ST_Z] <= alu_in.zero;
        status_q[CMA_ST_DC] <= alu_in.sub ? !alu_in.dcarry : alu_in.dcarry;
        status_q[CMA_ST_C] <= alu_in.sub ? !alu_in.carry : alu_in.carry;
      end else if (wr && core_hit && eff_off == CMA_OFF_STATUS) begin
        status_q[2:0] <= acc_req.wdata[2:0];
      end
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= CMA_VEC_RESET;
    end else if (wr && core_hit && eff_off == CMA_OFF_PCL) begin
      pc_q <= wrap_pc({program_counter_high_latch_q[6:0], acc_req.wdata});
    end else begin
      case (pc_op)
        CMA_PC_INC: pc_q <= wrap_pc(pc_q + 15'h0001);
        CMA_PC_JUMP: pc_q <= wrap_pc(pc_target);
        CMA_PC_CALL: pc_q <= wrap_pc(pc_target);
        CMA_PC_RET: pc_q <= stk_top;
        CMA_PC_IRQ: pc_q <= CMA_VEC_IRQ;
        default: pc_q <= pc_q;
      endcase
    end
  end

  // ****************************************
  // Stack fault flags
  // ****************************************
  // A new fault in the clearing cycle keeps the flag set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      ovf_q <= stk_ovf || (ovf_q && !stk_ovf_clear);
      unf_q <= stk_unf || (unf_q && !stk_unf_clear);
      soft_reset_q <= (stk_ovf || stk_unf) && stack_fault_reset_en;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign acc_busy = state_q != CMA_IDLE;
  assign acc_done = state_q == CMA_DONE;
  assign acc_rdata = rdata_q;
  assign acc_hi_endurance = he_q;
  assign pfm_rd = pfm_rd_q;
  assign pfm_addr = pfm_addr_q;
  assign pc = pc_q;
  assign stack_overflow_flag = ovf_q;
  assign stack_underflow_flag = unf_q;
  assign soft_reset = soft_reset_q;
  assign status_out = {3'h0, status_q};
  assign working_accumulator = working_accumulator_q;
  assign bank_selector = {3'h0, bsr_q};
  assign interrupt_control = interrupt_control_q;
  assign program_counter_high_latch = program_counter_high_latch_q;

endmodule

//--- verilog/cma_pkg.sv
/*
 * Shared constants and types for the core memory addressing block: core
 * register offsets, status bit positions, data memory map, stack and program
 * counter sizes, access states and the carrier structs.
 * Assumes one clock domain and that the CPU sequencer drives every request.
 */
package cma_pkg;

  // ****************************************
  // Core register offsets within a bank
  // ****************************************
  localparam logic [6:0] CMA_OFF_IND0 = 7'h00;
  localparam logic [6:0] CMA_OFF_IND1 = 7'h01;
  localparam logic [6:0] CMA_OFF_PCL = 7'h02;
  localparam logic [6:0] CMA_OFF_STATUS = 7'h03;
  localparam logic [6:0] CMA_OFF_P0L = 7'h04;
  localparam logic [6:0] CMA_OFF_P0H = 7'h05;
  localparam logic [6:0] CMA_OFF_P1L = 7'h06;
  localparam logic [6:0] CMA_OFF_P1H = 7'h07;
  localparam logic [6:0] CMA_OFF_BSR = 7'h08;
  localparam logic [6:0] CMA_OFF_WORKING_ACCUMULATOR = 7'h09;
  localparam logic [6:0] CMA_OFF_PROGRAM_COUNTER_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] CMA_OFF_INTERRUPT_CONTROL = 7'h0b;
  localparam logic [6:0] CMA_OFF_SFR = 7'h0c;
  localparam logic [6:0] CMA_OFF_GPR = 7'h20;
  localparam logic [6:0] CMA_OFF_COMMON = 7'h70;

  // ****************************************
  // Status bits and reset values
  // ****************************************
  localparam int CMA_ST_TO = 4;
  localparam int CMA_ST_PD = 3;
  localparam int CMA_ST_Z = 2;
  localparam int CMA_ST_DC = 1;
  localparam int CMA_ST_C = 0;
  localparam logic [4:0] CMA_STATUS_RST = 5'h18;
  localparam logic [7:0] CMA_REG_RST = 8'h00;

  // ****************************************
  // Program space, stack and data map
  // ****************************************
  localparam int CMA_PC_W = 15;
  localparam int CMA_PFM_W = 14;
  localparam int CMA_STK_DEPTH = 16;
  localparam int CMA_STK_CW = 5;
  localparam logic [14:0] CMA_VEC_RESET = 15'h0000;
  localparam logic [14:0] CMA_VEC_IRQ = 15'h0004;
  localparam int CMA_PTR_PROG_BIT = 15;
  localparam int CMA_HE_LSB = 7;
  localparam int CMA_BANK_W = 5;
  localparam logic [7:0] CMA_GPR_BYTES = 8'h50;
  localparam logic [4:0] CMA_GPR_BANKS = 5'h03;
  localparam int CMA_RAM_AW = 8;
  localparam logic [3:0] CMA_COMMON_PAGE = 4'hf;

  typedef enum logic [1:0] {
    CMA_IDLE = 2'b00,
    CMA_WAIT = 2'b01,
    CMA_PFM = 2'b11,
    CMA_DONE = 2'b10
  } cma_state_type;

  typedef enum logic [2:0] {
    CMA_PC_HOLD = 3'h0,
    CMA_PC_INC = 3'h1,
    CMA_PC_JUMP = 3'h2,
    CMA_PC_CALL = 3'h3,
    CMA_PC_RET = 3'h4,
    CMA_PC_IRQ = 3'h5
  } cma_pc_op_type;

  typedef enum logic [1:0] {
    CMA_RG_CORE = 2'h0,
    CMA_RG_SFR = 2'h1,
    CMA_RG_GPR = 2'h2,
    CMA_RG_COMMON = 2'h3
  } cma_region_type;

  typedef struct packed {
    logic write;
    logic [6:0] offset;
    logic [7:0] wdata;
  } cma_req_type;

  typedef struct packed {
    logic we;
    logic sub;
    logic zero;
    logic dcarry;
    logic carry;
  } cma_alu_type;

endpackage

//--- verilog/cma_mem.sv
/*
 * Small synchronous RAM with a registered read port, holding the general
 * and common data RAM. Read data appear one clock after the address.
 * Assumes one write or read per clock on a single port.
 */
`timescale 1ns/1ps
module cma_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule

//--- verilog/cma_stack.sv
/*
 * Hardware return stack: sixteen program counter words with a registered
 * top-of-stack and overflow/underflow detection.
 * Assumes push and pop never arrive in the same clock.
 */
`timescale 1ns/1ps
module cma_stack
  import cma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [CMA_PC_W-1:0] push_data,
  output logic [CMA_PC_W-1:0] top_q,
  output logic overflow,
  output logic underflow
);

  logic [CMA_PC_W-1:0] mem [0:CMA_STK_DEPTH-1];
  logic [CMA_STK_CW-1:0] count_q;
  logic full;
  logic empty;

  assign full = count_q == CMA_STK_CW'(CMA_STK_DEPTH);
  assign empty = count_q == '0;
  assign overflow = push && full;
  assign underflow = pop && empty;

  // Full stack keeps its contents; the lost push is only flagged
  always_ff @(posedge sys_clk) begin
    if (push && !full) begin
      mem[count_q[3:0]] <= push_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      top_q <= '0;
    end else if (push && !full) begin
      count_q <= count_q + 5'h01;
      top_q <= push_data;
    end else if (pop && !empty) begin
      count_q <= count_q - 5'h01;
      top_q <= (count_q > 5'h01) ? mem[4'(count_q - 5'h02)] : '0;
    end
  end

endmodule

//--- testbench/cma_core_addr_asserts.sv
/*
 * Checker for cma_core_addr: access latency, program reads, flags, stack.
 * Assumes it is bound to every instance and sees the top ports only.
 */
`timescale 1ns/1ps
module cma_core_addr_chk
  import cma_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic acc_valid,
  input wire cma_req_type acc_req,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_hi_endurance,
  input wire logic pfm_rd,
  input wire logic [CMA_PC_W-1:0] pfm_addr,
  input wire logic [CMA_PFM_W-1:0] pfm_word,
  input wire logic wdt_expire,
  input wire logic wdt_clear,
  input wire logic sleep_enter,
  input wire cma_pc_op_type pc_op,
  input wire logic [CMA_PC_W-1:0] pc,
  input wire logic stack_fault_reset_en,
  input wire logic stack_overflow_flag,
  input wire logic soft_reset,
  input wire logic [7:0] status_out,
  input wire logic [7:0] bank_selector
);
  // ****************************************
  // Helpers
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic [14:0] pfm_top = LARGE_VARIANT ? 15'h3fff : 15'h1fff;
  wire logic [7:0] word_lo = pfm_word[7:0];
  wire logic [1:0] to_pd = status_out[4:3];
  wire logic pcl_wr = acc_valid && !acc_busy && acc_req.write && acc_req.offset == CMA_OFF_PCL;

  // ****************************************
  // Assertions
  // ****************************************
  take_done_a: assert property (
    acc_valid && !acc_busy |-> ##[2:3] acc_done) else $error("Access finished late");
  pfm_word_a: assert property (
    pfm_rd |-> ##2 acc_done && acc_rdata == $past(word_lo)) else $error("Program byte wrong");
  pfm_wrap_a: assert property (
    pfm_rd |-> pfm_addr <= pfm_top) else $error("Program address not wrapped");
  hi_end_a: assert property (
    pfm_rd |-> ##2 acc_hi_endurance == (pfm_addr > pfm_top - 15'h0080))
    else $error("High endurance flag wrong");
  status_zero_a: assert property (status_out[7:5] == 3'h0)
    else $error("Status upper bits set");
  bank_bits_a: assert property (bank_selector[7:5] == 3'h0)
    else $error("Bank selector upper bits set");
  irq_vec_a: assert property (
    pc_op == CMA_PC_IRQ && !pcl_wr |=> pc == CMA_VEC_IRQ) else $error("Interrupt vector wrong");
  to_pd_keep_a: assert property (
    !wdt_expire && !wdt_clear && !sleep_enter |=> $stable(to_pd))
    else $error("Reset status bits changed");
  ovf_reset_a: assert property (
    $rose(stack_overflow_flag) |-> soft_reset == $past(stack_fault_reset_en))
    else $error("Soft reset wrong on overflow");

  cover property (pfm_rd);
  cover property ($rose(stack_overflow_flag));
  cover property (soft_reset);
  cover property (pc_op == CMA_PC_IRQ);
endmodule

bind cma_core_addr cma_core_addr_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (
  .sys_clk(sys_clk), .rst(rst), .acc_valid(acc_valid), .acc_req(acc_req),
  .acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata),
  .acc_hi_endurance(acc_hi_endurance), .pfm_rd(pfm_rd), .pfm_addr(pfm_addr),
  .pfm_word(pfm_word), .wdt_expire(wdt_expire), .wdt_clear(wdt_clear),
  .sleep_enter(sleep_enter), .pc_op(pc_op), .pc(pc),
  .stack_fault_reset_en(stack_fault_reset_en), .stack_overflow_flag(stack_overflow_flag),
  .soft_reset(soft_reset), .status_out(status_out), .bank_selector(bank_selector));

//--- testbench/cma_pfm_model.sv
/*
 * Program memory model: answers a read the cycle after pfm_rd.
 * Assumes pfm_addr is held by the core; word is valid for one cycle only.
 */
`timescale 1ns/1ps
module cma_pfm_model
  import cma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pfm_rd,
  input wire logic [CMA_PC_W-1:0] pfm_addr,
  output logic [CMA_PFM_W-1:0] pfm_word
);
  initial pfm_word = 14'h2aaa;
  // Read only, no write path at all
  always @(posedge sys_clk) begin
    if (pfm_rd)
      pfm_word <= pfm_addr[13:0] ^ 14'h1b3c;
    else
      pfm_word <= ~pfm_word ^ 14'h0155;
  end
endmodule

//--- testbench/tb.sv
/*
 * Self-checking bench for cma_core_addr: registers, banks, pointers,
 * program reads, status flags and return stack.
 * Assumes cma_pfm_model as program memory; random seed is fixed.
 */
`timescale 1ns/1ps
module tb;
  import cma_pkg::*;
  logic sys_clk, rst, acc_valid, acc_busy, acc_done, acc_hi_endurance, pfm_rd;
  logic wdt_expire, wdt_clear, sleep_enter, stack_fault_reset_en, stk_ovf_clear;
  logic stk_unf_clear, stack_overflow_flag, stack_underflow_flag, soft_reset;
  cma_req_type acc_req;
  cma_alu_type alu_in;
  cma_pc_op_type pc_op;
  logic [7:0] acc_rdata, status_out, working_accumulator, bank_selector;
  logic [7:0] interrupt_control, program_counter_high_latch, d;
  logic [7:0] ram_m [0:383];
  logic [7:0] stx [0:2] = '{8'h0a, 8'h12, 8'h1a};
  logic [14:0] pfm_addr, pc_target, pc, a;
  logic [14:0] rets [0:15];
  logic [14:0] pa [0:2] = '{15'h3f80, 15'h3f7f, 15'h7fff};
  logic [13:0] pfm_word;
  logic [4:0] pv;
  int bad_count, n_tests, seed, cyc, lat, lat_d, b, o;
  int aq[$];
  assign {stk_unf_clear, stk_ovf_clear, wdt_clear, sleep_enter, wdt_expire} = pv;

  cma_core_addr #(.LARGE_VARIANT(1'b1)) uut (
    .sys_clk(sys_clk), .rst(rst), .acc_valid(acc_valid), .acc_req(acc_req),
    .acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata),
    .acc_hi_endurance(acc_hi_endurance), .pfm_rd(pfm_rd), .pfm_addr(pfm_addr),
    .pfm_word(pfm_word), .alu_in(alu_in), .wdt_expire(wdt_expire), .wdt_clear(wdt_clear),
    .sleep_enter(sleep_enter), .pc_op(pc_op), .pc_target(pc_target), .pc(pc),
    .stack_fault_reset_en(stack_fault_reset_en), .stk_ovf_clear(stk_ovf_clear),
    .stk_unf_clear(stk_unf_clear), .stack_overflow_flag(stack_overflow_flag),
    .stack_underflow_flag(stack_underflow_flag), .soft_reset(soft_reset),
    .status_out(status_out), .working_accumulator(working_accumulator),
    .bank_selector(bank_selector), .interrupt_control(interrupt_control),
    .program_counter_high_latch(program_counter_high_latch));
  cma_pfm_model pm (.sys_clk(sys_clk), .pfm_rd(pfm_rd), .pfm_addr(pfm_addr),
    .pfm_word(pfm_word));

  // ****************************************
  // Clock, timeout and bench tasks
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      test_done;
    end
  end
  function automatic logic [7:0] fb(input logic [14:0] x);
    return x[7:0] ^ 8'h3c;
  endfunction
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task acc(input logic w, input logic [6:0] f, input logic [7:0] v);
    acc_valid <= 1'b1;
    acc_req <= '{w, f, v};
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (acc_done !== 1'b1 && lat < 8);
    @(posedge sys_clk);
  endtask
  task wr(input logic [6:0] f, input logic [7:0] v);
    acc(1'b1, f, v);
  endtask
  task rd(input string s, input logic [6:0] f, input logic [7:0] e);
    acc(1'b0, f, 8'h00);
    chk(s, 16'(acc_rdata), 16'(e));
  endtask
  task op(input cma_pc_op_type o, input logic [14:0] t, input logic [4:0] v);
    @(posedge sys_clk);
    pc_op <= o;
    pc_target <= t;
    pv <= v;
    @(posedge sys_clk);
    pc_op <= CMA_PC_HOLD;
    pv <= 5'h00;
    @(negedge sys_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 18107;
    rst = 1'b1;
    acc_valid = 1'b0;
    acc_req = '0;
    alu_in = '0;
    pc_op = CMA_PC_HOLD;
    pc_target = 15'h0000;
    pv = 5'h00;
    stack_fault_reset_en = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("pc", 16'(pc), 16'h0000);
    chk("status", 16'(status_out), 16'h0018);
    $display("test reset done");
    @(posedge sys_clk);
    wr(CMA_OFF_BSR, 8'hff);
    chk("bank", 16'(bank_selector), 16'h001f);
    for (int i = 0; i < 6; i++) begin
      b = $random(seed);
      d = $random(seed);
      wr(CMA_OFF_BSR, 8'(b));
      wr(CMA_OFF_WORKING_ACCUMULATOR, d);
      rd("working_accumulator", CMA_OFF_WORKING_ACCUMULATOR, d);
      rd("bank", CMA_OFF_BSR, 8'(b & 31));
    end
    wr(CMA_OFF_INTERRUPT_CONTROL, 8'ha5);
    rd("interrupt_control", CMA_OFF_INTERRUPT_CONTROL, 8'ha5);
    wr(CMA_OFF_PROGRAM_COUNTER_HIGH_LATCH, 8'h25);
    chk("latch", 16'(program_counter_high_latch), 16'h0025);
    wr(CMA_OFF_PCL, 8'h3c);
    chk("pcl load", 16'(pc), 16'h253c);
    $display("test core done");
    for (int i = 0; i < 12; i++) begin
      b = $unsigned($random(seed)) % 3;
      o = 32 + $unsigned($random(seed)) % 80;
      d = $random(seed);
      wr(CMA_OFF_BSR, 8'(b));
      wr(7'(o), d);
      ram_m[b * 128 + o] = d;
      aq.push_back(b * 128 + o);
    end
    foreach (aq[i]) begin
      wr(CMA_OFF_BSR, 8'(aq[i] / 128));
      rd("gpr", 7'(aq[i] % 128), ram_m[aq[i]]);
    end
    wr(CMA_OFF_BSR, 8'h05);
    rd("empty bank", CMA_OFF_GPR, 8'h00);
    wr(CMA_OFF_SFR, 8'h5a);
    rd("sfr", CMA_OFF_SFR, 8'h00);
    wr(7'h75, 8'hc3);
    wr(CMA_OFF_BSR, 8'h1f);
    rd("common", 7'h75, 8'hc3);
    wr(CMA_OFF_P1H, 8'h01);
    wr(CMA_OFF_P1L, 8'h25);
    wr(CMA_OFF_IND1, 8'h9e);
    wr(CMA_OFF_BSR, 8'h02);
    rd("ptr data", 7'h25, 8'h9e);
    rd("ptr back", CMA_OFF_IND1, 8'h9e);
    lat_d = lat;
    $display("test data map done");
    for (int i = 0; i < 8; i++) begin
      a = (i < 3) ? pa[i] : 15'($random(seed));
      wr(CMA_OFF_P0H, {1'b1, a[14:8]});
      wr(CMA_OFF_P0L, a[7:0]);
      rd("pfm byte", CMA_OFF_IND0, fb(a));
      chk("pfm lat", 16'(lat), 16'(lat_d + 1));
      chk("pfm addr", 16'(pfm_addr), {2'b00, a[13:0]});
      chk("hi end", 16'(acc_hi_endurance), 16'(a[13:7] == 7'h7f));
      wr(CMA_OFF_IND0, ~fb(a));
      rd("pfm kept", CMA_OFF_IND0, fb(a));
    end
    $display("test program read done");
    wr(CMA_OFF_STATUS, 8'hff);
    chk("status ff", 16'(status_out), 16'h001f);
    wr(CMA_OFF_STATUS, 8'h00);
    chk("status 00", 16'(status_out), 16'h0018);
    alu_in <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    wr(CMA_OFF_STATUS, 8'h06);
    chk("alu wins", 16'(status_out), 16'h0019);
    alu_in <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    op(CMA_PC_HOLD, 15'h0000, 5'h00);
    chk("borrow", 16'(status_out), 16'h001a);
    @(posedge sys_clk);
    alu_in <= '0;
    for (int k = 0; k < 3; k++) begin
      op(CMA_PC_HOLD, 15'h0000, 5'(1 << k));
      chk("to pd", 16'(status_out), 16'(stx[k]));
    end
    $display("test status done");
    op(CMA_PC_JUMP, 15'h0100, 5'h00);
    for (int i = 0; i < 17; i++) begin
      if (i < 16)
        rets[i] = pc + 15'h0001;
      op(CMA_PC_CALL, 15'h0200 + 15'(i * 16), 5'h00);
      chk("ovf", 16'(stack_overflow_flag), 16'(i == 16));
    end
    chk("soft ovf", 16'(soft_reset), 16'h0001);
    for (int i = 15; i >= 0; i--) begin
      op(CMA_PC_RET, 15'h0000, 5'h00);
      chk("ret", 16'(pc), 16'(rets[i]));
    end
    @(posedge sys_clk);
    stack_fault_reset_en <= 1'b0;
    op(CMA_PC_RET, 15'h0000, 5'h00);
    chk("unf", 16'(stack_underflow_flag), 16'h0001);
    chk("soft off", 16'(soft_reset), 16'h0000);
    op(CMA_PC_HOLD, 15'h0000, 5'h18);
    chk("clear", 16'({stack_overflow_flag, stack_underflow_flag}), 16'h0000);
    op(CMA_PC_JUMP, 15'h0123, 5'h00);
    op(CMA_PC_IRQ, 15'h0000, 5'h00);
    chk("irq", 16'(pc), 16'h0004);
    op(CMA_PC_RET, 15'h0000, 5'h00);
    chk("irq ret", 16'(pc), 16'h0123);
    $display("test stack done");
    test_done;
  end
endmodule
